// >>> hw/ascp_fifo.v
`timescale 1ns/1ps
`include "ascp_map.vh"

module ascp_fifo #(
	parameter DEPTH = `ASCP_DEPTH,
	parameter AW = 9
)(
	// clock, reset, enable
	input wire ref_clk,
	input wire sys_rst,
	input wire clk_en,
	// register port
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata_reg,
	output reg reg_rvalid_reg,
	// samples and events from the front end
	input wire sample_valid,
	input wire [11:0] sample_x,
	input wire [11:0] sample_y,
	input wire [11:0] sample_z,
	input wire activity_evt,
	input wire inactivity_evt,
	// status outputs
	output reg buf_ready_reg,
	output reg buf_watermark_reg,
	output reg buf_overrun_reg,
	output reg measure_on_reg
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	reg [7:0] buffer_sample_count_low_reg; // low byte of sample count
	reg [7:0] buffer_control_reg; // mode, format, count msb
	reg [7:0] power_control_reg; // power mode, impact band
	reg [15:0] mem [0:DEPTH-1]; // sample storage
	reg [AW-1:0] wr_ptr_reg;
	reg [AW-1:0] rd_ptr_reg;
	reg [AW:0] fill_reg; // entries held
	reg [2:0] pend_reg; // axes of the latched set still to store
	reg [11:0] set_x_reg;
	reg [11:0] set_y_reg;
	reg [11:0] set_z_reg;
	reg first_reg; // next stored entry opens a series
	reg phase_reg; // 0: high byte next, 1: low byte next
	reg ovr_reg; // sticky overrun
	reg trig_reg; // activity seen, collecting post-event
	reg frozen_reg; // capture complete
	reg [AW:0] post_reg; // post-event entries stored
	reg win_reg; // inside an activity interval

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	wire [1:0] fmode = buffer_control_reg[`ASCP_CTL_MODE_LSB+1:`ASCP_CTL_MODE_LSB];
	wire [2:0] fmt = buffer_control_reg[`ASCP_CTL_FMT_LSB+2:`ASCP_CTL_FMT_LSB];
	wire [8:0] samp_cnt = {buffer_control_reg[`ASCP_CTL_CNT_MSB], buffer_sample_count_low_reg};
	wire [1:0] pmode = power_control_reg[`ASCP_PWR_MODE_LSB+1:`ASCP_PWR_MODE_LSB];
	wire standby = (pmode == `ASCP_PM_STANDBY);
	wire measuring = (pmode == `ASCP_PM_MEASURE);
	wire en = (fmode != `ASCP_MODE_OFF);
	wire peak_sel = (fmt == `ASCP_FMT_PEAK);
	wire [2:0] mask = (fmt == `ASCP_FMT_XYZ) ? 3'h7 : fmt; // x bit0, y bit1, z bit2
	wire [AW:0] cap = (mask == 3'h7) ? `ASCP_CAP_3AXIS : `ASCP_CAP_FULL;
	wire full = (fill_reg >= cap);

	// ----------------------------------------------------------------
	// peak trackers
	// ----------------------------------------------------------------
	wire [11:0] ev_x;
	wire [11:0] ev_y;
	wire [11:0] ev_z;
	wire ev_have;
	wire [11:0] mx_x;
	wire [11:0] mx_y;
	wire [11:0] mx_z;
	wire pk_upd = sample_valid & measuring & peak_sel & en & win_reg;
	wire rd_hit = reg_rd & clk_en;
	wire max_clr = rd_hit & (reg_addr == `ASCP_OFS_MAXPK_LAST); // reading the last byte restarts the search

	// per-interval peak, restarted at each activity trigger
	ascp_peak #(.W(12)) u_event_peak (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.clr(activity_evt),
		.upd(pk_upd),
		.in_x(sample_x),
		.in_y(sample_y),
		.in_z(sample_z),
		.pk_x_reg(ev_x),
		.pk_y_reg(ev_y),
		.pk_z_reg(ev_z),
		.have_reg(ev_have)
	);

	// overall maximum, restarted when its last byte is read
	ascp_peak #(.W(12)) u_max_peak (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.clr(max_clr),
		.upd(pk_upd),
		.in_x(sample_x),
		.in_y(sample_y),
		.in_z(sample_z),
		.pk_x_reg(mx_x),
		.pk_y_reg(mx_y),
		.pk_z_reg(mx_z),
		.have_reg()
	);

	// ----------------------------------------------------------------
	// write and pop control
	// ----------------------------------------------------------------
	function [11:0] mag12;
		input [11:0] v;
		begin
			mag12 = v[11] ? (~v + 12'h001) : v;
		end
	endfunction

	wire [11:0] thr = power_control_reg[`ASCP_PWR_THR_BIT] ? `ASCP_IMPACT_THR_HI : `ASCP_IMPACT_THR_LO;
	wire wake = (pmode == `ASCP_PM_IMPACT) & sample_valid &
		((mag12(sample_x) >= thr) | (mag12(sample_y) >= thr) | (mag12(sample_z) >= thr));
	wire readable = (fill_reg != 0) & ((fmode != `ASCP_MODE_TRIG) | frozen_reg);
	wire data_rd = rd_hit & (reg_addr == `ASCP_OFS_DATA);
	wire pop = data_rd & phase_reg & readable;
	wire wr_try = (pend_reg != 3'h0) & en & ~((fmode == `ASCP_MODE_TRIG) & frozen_reg);
	wire wr_go = wr_try & (~full | (fmode != `ASCP_MODE_OLDEST) | pop);
	wire drop = wr_go & full & ~pop;
	wire ovr_evt = wr_try & full & ~pop;
	wire smp_go = sample_valid & measuring & en & ~peak_sel & (pend_reg == 3'h0);
	wire pk_go = inactivity_evt & win_reg & ev_have & peak_sel & en;
	wire [2:0] pick = pend_reg[0] ? 3'h1 : (pend_reg[1] ? 3'h2 : 3'h4);
	wire [11:0] pick_val = pend_reg[0] ? set_x_reg : (pend_reg[1] ? set_y_reg : set_z_reg);
	wire act_go = activity_evt & (fmode == `ASCP_MODE_TRIG) & ~trig_reg & ~frozen_reg & measuring;
	wire post_done = trig_reg & wr_go & ((post_reg + 10'h001) >= {1'b0, samp_cnt});

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	// mode and count change only in standby; wake forces measurement
	always @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			buffer_sample_count_low_reg <= `ASCP_COUNT_LO_RST;
			buffer_control_reg <= `ASCP_CTL_RST;
			power_control_reg <= `ASCP_POWER_RST;
		end
		else if (clk_en)
		begin
			if (reg_wr & standby & (reg_addr == `ASCP_OFS_COUNT_LO))
				buffer_sample_count_low_reg <= reg_wdata;
			if (reg_wr & standby & (reg_addr == `ASCP_OFS_CTL))
				buffer_control_reg <= reg_wdata;
			if (wake)
				power_control_reg[`ASCP_PWR_MODE_LSB+1:`ASCP_PWR_MODE_LSB] <= `ASCP_PM_MEASURE;
			else if (reg_wr & (reg_addr == `ASCP_OFS_POWER))
				power_control_reg <= reg_wdata;
		end
	end

	// ----------------------------------------------------------------
	// storage, pointers and capture state
	// ----------------------------------------------------------------
	// entry write path
	always @(posedge ref_clk)
	begin
		if (clk_en & wr_go)
			mem[wr_ptr_reg] <= {pick_val, 3'b000, first_reg};
	end

	// pointer, fill and flag updates
	always @(posedge ref_clk)
	begin
		if (sys_rst | (clk_en & ~en))
		begin
			wr_ptr_reg <= {AW{1'b0}};
			rd_ptr_reg <= {AW{1'b0}};
			fill_reg <= {(AW+1){1'b0}};
			pend_reg <= 3'h0;
			first_reg <= 1'b0;
			phase_reg <= 1'b0;
			ovr_reg <= 1'b0;
			trig_reg <= 1'b0;
			frozen_reg <= 1'b0;
			post_reg <= {(AW+1){1'b0}};
			win_reg <= 1'b0;
		end
		else if (clk_en)
		begin
			if (wr_go)
				wr_ptr_reg <= wr_ptr_reg + 9'h001;
			if (pop | drop)
				rd_ptr_reg <= rd_ptr_reg + 9'h001;
			// drop and pop never coincide, so a drop keeps the fill
			if (wr_go & ~pop & ~drop)
				fill_reg <= fill_reg + 10'h001;
			else if (pop & ~wr_go)
				fill_reg <= fill_reg - 10'h001;
			// byte phase flips only while data is there to pop
			if (data_rd & readable)
				phase_reg <= ~phase_reg;
			// latch a new set, or retire the axis just offered
			if (smp_go)
			begin
				pend_reg <= mask;
				set_x_reg <= sample_x;
				set_y_reg <= sample_y;
				set_z_reg <= sample_z;
				first_reg <= 1'b1;
			end
			else if (pk_go)
			begin
				pend_reg <= 3'h7;
				set_x_reg <= ev_x;
				set_y_reg <= ev_y;
				set_z_reg <= ev_z;
				first_reg <= 1'b1;
			end
			else if (wr_try)
			begin
				pend_reg <= pend_reg & ~pick;
				first_reg <= 1'b0;
			end
			// overrun: a new event wins over the clearing read
			if (ovr_evt)
				ovr_reg <= 1'b1;
			else if (rd_hit & (reg_addr == `ASCP_OFS_STATUS) & (fill_reg == 0))
				ovr_reg <= 1'b0;
			// triggered capture: arm, count post-event entries, freeze
			if (act_go)
			begin
				trig_reg <= 1'b1;
				post_reg <= {(AW+1){1'b0}};
				if (samp_cnt == 9'h000)
					frozen_reg <= 1'b1;
			end
			else if (post_done)
			begin
				trig_reg <= 1'b0;
				frozen_reg <= 1'b1;
			end
			else if (trig_reg & wr_go)
				post_reg <= post_reg + 10'h001;
			else if (frozen_reg & (fill_reg == 0))
				frozen_reg <= 1'b0;
			// activity interval for peak capture
			if (activity_evt & peak_sel & measuring)
				win_reg <= 1'b1;
			else if (inactivity_evt)
				win_reg <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// read data and status outputs
	// ----------------------------------------------------------------
	// registered read answer, one cycle after the read strobe
	always @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			reg_rdata_reg <= 8'h00;
			reg_rvalid_reg <= 1'b0;
			buf_ready_reg <= 1'b0;
			buf_watermark_reg <= 1'b0;
			buf_overrun_reg <= 1'b0;
			measure_on_reg <= 1'b0;
		end
		else if (clk_en)
		begin
			reg_rvalid_reg <= reg_rd;
			case (reg_addr)
				`ASCP_OFS_STATUS: reg_rdata_reg <= {5'h00, ovr_reg, buf_watermark_reg, buf_ready_reg};
				`ASCP_OFS_FILL_HI: reg_rdata_reg <= {6'h00, fill_reg[AW:8]}; // fill reaches 512, two high bits
				`ASCP_OFS_FILL_LO: reg_rdata_reg <= fill_reg[7:0];
				`ASCP_OFS_COUNT_LO: reg_rdata_reg <= buffer_sample_count_low_reg;
				`ASCP_OFS_CTL: reg_rdata_reg <= buffer_control_reg;
				`ASCP_OFS_POWER: reg_rdata_reg <= power_control_reg;
				`ASCP_OFS_DATA: reg_rdata_reg <= ~readable ? 8'h00 :
					(phase_reg ? mem[rd_ptr_reg][7:0] : mem[rd_ptr_reg][15:8]);
				8'h15: reg_rdata_reg <= mx_x[11:4];
				8'h16: reg_rdata_reg <= {mx_x[3:0], 4'h0};
				8'h17: reg_rdata_reg <= mx_y[11:4];
				8'h18: reg_rdata_reg <= {mx_y[3:0], 4'h0};
				8'h19: reg_rdata_reg <= mx_z[11:4];
				8'h1A: reg_rdata_reg <= {mx_z[3:0], 4'h0};
				default: reg_rdata_reg <= 8'h00;
			endcase
			buf_ready_reg <= readable;
			buf_watermark_reg <= en & (fill_reg >= {1'b0, samp_cnt});
			buf_overrun_reg <= ovr_reg | ovr_evt;
			measure_on_reg <= measuring;
		end
	end

endmodule // ascp_fifo

// >>> common/ascp_map.vh
`ifndef ASCP_MAP_VH
`define ASCP_MAP_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define ASCP_OFS_STATUS 8'h04
`define ASCP_OFS_FILL_HI 8'h06
`define ASCP_OFS_FILL_LO 8'h07
`define ASCP_OFS_MAXPK_BASE 8'h15
`define ASCP_OFS_MAXPK_LAST 8'h1A
`define ASCP_OFS_COUNT_LO 8'h39
`define ASCP_OFS_CTL 8'h3A
`define ASCP_OFS_POWER 8'h3F
`define ASCP_OFS_DATA 8'h42

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define ASCP_COUNT_LO_RST 8'h80
`define ASCP_CTL_RST 8'h00
`define ASCP_POWER_RST 8'h00

// ----------------------------------------------------------------
// buffer control fields
// ----------------------------------------------------------------
`define ASCP_CTL_CNT_MSB 0
`define ASCP_CTL_MODE_LSB 1
`define ASCP_CTL_FMT_LSB 3
`define ASCP_MODE_OFF 2'h0
`define ASCP_MODE_STREAM 2'h1
`define ASCP_MODE_TRIG 2'h2
`define ASCP_MODE_OLDEST 2'h3
`define ASCP_FMT_XYZ 3'h0
`define ASCP_FMT_PEAK 3'h7

// ----------------------------------------------------------------
// power control fields and impact thresholds
// ----------------------------------------------------------------
`define ASCP_PWR_MODE_LSB 0
`define ASCP_PWR_THR_BIT 3
`define ASCP_PM_STANDBY 2'h0
`define ASCP_PM_IMPACT 2'h1
`define ASCP_PM_MEASURE 2'h3
`define ASCP_IMPACT_THR_LO 12'h064
`define ASCP_IMPACT_THR_HI 12'h12C

// ----------------------------------------------------------------
// storage geometry
// ----------------------------------------------------------------
`define ASCP_DEPTH 512
`define ASCP_CAP_3AXIS 10'h1FE
`define ASCP_CAP_FULL 10'h200

`endif

// >>> hw/ascp_peak.v
`timescale 1ns/1ps

// ----------------------------------------------------------------
// largest-magnitude x/y/z tracker
// ----------------------------------------------------------------
module ascp_peak #(
	parameter W = 12
)(
	// clock and control
	input wire ref_clk,
	input wire sys_rst,
	input wire clk_en,
	// restart search, offer a sample
	input wire clr,
	input wire upd,
	input wire [W-1:0] in_x,
	input wire [W-1:0] in_y,
	input wire [W-1:0] in_z,
	// best set so far
	output reg [W-1:0] pk_x_reg,
	output reg [W-1:0] pk_y_reg,
	output reg [W-1:0] pk_z_reg,
	output reg have_reg
);

	reg [2*W+1:0] pk_mag_reg; // squared magnitude of best set
	wire signed [W-1:0] sx = in_x;
	wire signed [W-1:0] sy = in_y;
	wire signed [W-1:0] sz = in_z;
	wire [2*W-1:0] qx = sx * sx; // squares are never negative
	wire [2*W-1:0] qy = sy * sy;
	wire [2*W-1:0] qz = sz * sz;
	wire [2*W+1:0] mag = {2'b00, qx} + {2'b00, qy} + {2'b00, qz}; // sum of squares orders like root-sum-square
	wire take = upd & (clr | ~have_reg | (mag > pk_mag_reg));

	// keep the set with the largest magnitude; a clear restarts
	always @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			pk_x_reg <= {W{1'b0}};
			pk_y_reg <= {W{1'b0}};
			pk_z_reg <= {W{1'b0}};
			pk_mag_reg <= {(2*W+2){1'b0}};
			have_reg <= 1'b0;
		end
		else if (clk_en)
		begin
			if (take)
			begin
				pk_x_reg <= in_x;
				pk_y_reg <= in_y;
				pk_z_reg <= in_z;
				pk_mag_reg <= mag;
			end
			else if (clr)
			begin
				// a clear (a read or an activity trigger) empties the held set as well as the search
				pk_x_reg <= {W{1'b0}};
				pk_y_reg <= {W{1'b0}};
				pk_z_reg <= {W{1'b0}};
				pk_mag_reg <= {(2*W+2){1'b0}};
			end
			// a sample in the clearing cycle survives the clear
			if (clr)
				have_reg <= upd;
			else if (upd)
				have_reg <= 1'b1;
		end
	end

endmodule // ascp_peak

// >>> bench/ascp_fifo_monitor.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// port checker for the sample buffer
// ----------------------------------------------------------------
module ascp_fifo_monitor (
	// clock and reset
	input wire ref_clk,
	input wire sys_rst,
	input wire clk_en,
	// register port
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire reg_rvalid_reg,
	// samples and status
	input wire sample_valid,
	input wire buf_ready_reg,
	input wire buf_watermark_reg,
	input wire buf_overrun_reg,
	input wire measure_on_reg
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	wire acc = reg_rd || reg_wr; // any host access
	wire pwr_wr = reg_wr && reg_addr == 8'h3F; // power mode write
	// a read taken by the port
	sequence rd_taken;
		reg_rd && clk_en;
	endsequence
	// buffer switched off while not measuring
	sequence off_write;
		reg_wr && clk_en && reg_addr == 8'h3A && reg_wdata[2:1] == 2'h0 && !measure_on_reg;
	endsequence
	rd_answer_a: assert property (rd_taken |=> reg_rvalid_reg) else $error("read not answered");
	rd_only_a: assert property (!(reg_rd && clk_en) |=> !reg_rvalid_reg) else $error("stray answer");
	mode_off_a: assert property (off_write |-> ##[1:3] (!buf_ready_reg && !buf_overrun_reg))
		else $error("buffer kept data when off");
	ready_fall_a: assert property ($fell(buf_ready_reg) |-> $past(acc) || $past(acc, 2) || $past(acc, 3))
		else $error("ready dropped without access");
	wm_fall_a: assert property ($fell(buf_watermark_reg) |-> $past(acc) || $past(acc, 2) || $past(acc, 3))
		else $error("watermark dropped without access");
	ovr_hold_a: assert property (buf_overrun_reg && !acc && !$past(acc) && !$past(acc, 2) |=> buf_overrun_reg)
		else $error("overrun not sticky");
	wake_hold_a: assert property (measure_on_reg && !pwr_wr && !$past(pwr_wr) |=> measure_on_reg)
		else $error("left measurement alone");
	wake_cause_a: assert property ($rose(measure_on_reg) |-> $past(sample_valid || pwr_wr) ||
		$past(sample_valid || pwr_wr, 2)) else $error("measurement without cause");
endmodule // ascp_fifo_monitor

bind ascp_fifo ascp_fifo_monitor i_mon (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rvalid_reg(reg_rvalid_reg),
	.sample_valid(sample_valid), .buf_ready_reg(buf_ready_reg), .buf_watermark_reg(buf_watermark_reg),
	.buf_overrun_reg(buf_overrun_reg), .measure_on_reg(measure_on_reg));

// >>> bench/ascp_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// host processor on the register port
// ----------------------------------------------------------------
module ascp_host_model (
	// clock
	input wire ref_clk,
	// requests
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	// answers
	input wire [7:0] reg_rdata_reg,
	input wire reg_rvalid_reg
);
	// idle port at time zero
	initial
	begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// one write; callers reconfigure from standby, except the count write t_stream makes while measuring
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a; // released lines show no stale value
		reg_wdata <= ~d;
	endtask
	// one read; d is X when no answer comes back
	task rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		#1 d = (reg_rvalid_reg === 1'b1) ? reg_rdata_reg : 8'hXX;
	endtask
endmodule // ascp_host_model

// >>> bench/tb.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// testbench
// ----------------------------------------------------------------
module tb;
	logic ref_clk, sys_rst, clk_en, sample_valid, activity_evt, inactivity_evt;
	logic [11:0] sample_x, sample_y, sample_z;
	wire [7:0] reg_addr, reg_wdata, reg_rdata_reg;
	wire reg_wr, reg_rd, reg_rvalid_reg, buf_ready_reg, buf_watermark_reg, buf_overrun_reg, measure_on_reg;
	int error_cnt, tests_run, cyc;
	logic [7:0] rb, rl;
	logic [15:0] w;

	ascp_fifo i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_reg(reg_rdata_reg),
		.reg_rvalid_reg(reg_rvalid_reg), .sample_valid(sample_valid), .sample_x(sample_x), .sample_y(sample_y),
		.sample_z(sample_z), .activity_evt(activity_evt), .inactivity_evt(inactivity_evt),
		.buf_ready_reg(buf_ready_reg), .buf_watermark_reg(buf_watermark_reg), .buf_overrun_reg(buf_overrun_reg),
		.measure_on_reg(measure_on_reg));
	ascp_host_model i_host (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata_reg(reg_rdata_reg), .reg_rvalid_reg(reg_rvalid_reg));

	// 40 MHz clock
	initial
	begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	// compare and count
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// read one register and compare
	task rdc(input logic [7:0] a, input logic [7:0] e);
		i_host.rd(a, rb);
		chk(rb, e);
	endtask
	// pop one 16-bit entry, high byte first
	task rd16(output logic [15:0] v);
		i_host.rd(8'h42, rb);
		i_host.rd(8'h42, rl);
		v = {rb, rl};
	endtask
	// compare the fill level
	task fill_chk(input logic [15:0] e);
		i_host.rd(8'h06, rb);
		i_host.rd(8'h07, rl);
		chk({rb, rl}, e);
	endtask
	// one x/y/z set, spaced so the previous set is stored
	task smp(input logic [11:0] x, input logic [11:0] y, input logic [11:0] z);
		@(posedge ref_clk);
		sample_valid <= 1'b1;
		sample_x <= x;
		sample_y <= y;
		sample_z <= z;
		@(posedge ref_clk);
		sample_valid <= 1'b0;
		repeat (3) @(posedge ref_clk);
	endtask
	// configure in standby, then measure
	task cfg(input logic [7:0] cnt, input logic [7:0] ctl);
		i_host.wr(8'h3F, 8'h00);
		i_host.wr(8'h39, cnt);
		i_host.wr(8'h3A, ctl);
		i_host.wr(8'h3F, 8'h03);
	endtask
	// reset values and an unmapped place
	task t_reset;
		rdc(8'h39, 8'h80);
		rdc(8'h3A, 8'h00);
		rdc(8'h04, 8'h00);
		rdc(8'h55, 8'h00);
	endtask
	// watermark, frozen config, entry format
	task t_stream;
		cfg(8'h06, 8'h02);
		smp(12'h123, 12'h456, 12'h789);
		rdc(8'h04, 8'h01);
		smp(12'h123, 12'h456, 12'h789);
		rdc(8'h04, 8'h03);
		i_host.wr(8'h39, 8'h22);
		rdc(8'h39, 8'h06);
		rd16(w);
		chk(w, 16'h1231);
		rd16(w);
		chk(w, 16'h4560);
		fill_chk(16'h0004);
		rdc(8'h04, 8'h01);
	endtask
	// overfill in one mode and look at the oldest entry kept
	task t_full(input logic [7:0] ctl, input logic [7:0] first);
		cfg(8'h80, ctl);
		for (int i = 0; i < 171; i++)
			smp({i[7:0], 4'h0}, 12'h0F0, 12'h0F0);
		fill_chk(16'h01FE);
		rdc(8'h04, 8'h07);
		rd16(w);
		chk(w, {first, 8'h01});
	endtask
	// one activity (1) or inactivity (0) pulse from the front end
	task evt(input logic act);
		@(posedge ref_clk);
		if (act)
			activity_evt <= 1'b1;
		else
			inactivity_evt <= 1'b1;
		@(posedge ref_clk);
		activity_evt <= 1'b0;
		inactivity_evt <= 1'b0;
		repeat (2) @(posedge ref_clk);
	endtask
	// triggered capture: pre-event stream, count post-event entries, freeze, drain
	task t_trig;
		cfg(8'h03, 8'h04);
		smp(12'h111, 12'h222, 12'h333);
		smp(12'h444, 12'h555, 12'h666);
		rdc(8'h04, 8'h02);
		evt(1'b1);
		smp(12'h777, 12'h888, 12'h999);
		fill_chk(16'h0009);
		rdc(8'h04, 8'h03);
		rd16(w);
		chk(w, 16'h1111);
		repeat (8) rd16(w);
		rdc(8'h04, 8'h00);
	endtask
	// peak capture over one activity interval, then the overall maximum
	task t_peak;
		cfg(8'h80, 8'h3A);
		evt(1'b1); // thresholds set at the front end
		smp(12'h010, 12'h020, 12'h030);
		smp(12'hF00, 12'h000, 12'h000);
		smp(12'h005, 12'h005, 12'h005);
		evt(1'b0); // each event cleared before the next
		repeat (4) @(posedge ref_clk);
		fill_chk(16'h0003);
		rd16(w);
		chk(w, 16'hF001);
		rdc(8'h15, 8'hF0);
		rdc(8'h1A, 8'h00);
		rdc(8'h15, 8'h00);
	endtask
	// buffer off flushes
	task t_off;
		i_host.wr(8'h3F, 8'h00);
		i_host.wr(8'h3A, 8'h00);
		fill_chk(16'h0000);
		rdc(8'h04, 8'h00);
	endtask
	// impact watch in both bands
	task t_impact;
		cfg(8'h80, 8'h02);
		i_host.wr(8'h3F, 8'h01); // entered from measurement
		smp(12'd99, 12'd0, 12'd0);
		chk(measure_on_reg, 16'h0000);
		fill_chk(16'h0000);
		smp(12'd100, 12'd0, 12'd0);
		chk(measure_on_reg, 16'h0001);
		repeat (20) @(posedge ref_clk);
		chk(measure_on_reg, 16'h0001);
		i_host.wr(8'h3F, 8'h09);
		smp(12'd0, 12'd0, 12'hF38);
		chk(measure_on_reg, 16'h0000);
		smp(12'd0, 12'd0, 12'hED4);
		chk(measure_on_reg, 16'h0001);
	endtask
	// verdict and end of run
	task end_of_test;
		$display("errors %0d, checks %0d", error_cnt, tests_run);
		if (error_cnt == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// cut a hang short
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			error_cnt++;
			end_of_test;
		end
	end
	// main sequence
	initial
	begin
		sys_rst = 1'b1;
		clk_en = 1'b1;
		sample_valid = 1'b0;
		sample_x = 12'h000;
		sample_y = 12'h000;
		sample_z = 12'h000;
		activity_evt = 1'b0;
		inactivity_evt = 1'b0;
		repeat (8) @(posedge ref_clk);
		sys_rst <= 1'b0;
		t_reset;
		t_stream;
		t_off;
		t_full(8'h06, 8'h00);
		t_off;
		t_full(8'h02, 8'h01);
		t_off;
		t_trig;
		t_off;
		t_peak;
		t_off;
		t_impact;
		end_of_test;
	end
endmodule // tb
